// [design/char_framer.sv]
// Purpose: character sync/async line framer with sync hunt and sync release
// Assumes: line clock and data are sampled by clk through two flops each
// Notes: no bit stuffing anywhere; capture output is one-cycle strobe
//
// Contract
// - Default LSB first, normal sense; selectable
// - Transforms at line input and output only
// - Check window opens after start, includes stop
// - No error check means all outside window
// - Transparency delimiter bounds the control field
// - Sync or async; receiver needs one stop
// - Sync settings ignored in asynchronous mode
// - Two consecutive sync characters establish alignment
// - No data loaded before sync pair
// - Sync on idles uses FF
// - Idle characters discarded by default; code keeps them unless sync mode has a release char or drop count set
// - Zero count, no release: keep sync always
// - After release match, count then drop sync
// - Seven ORed release chars, first inside window
// - Inside-window release ignored outside window
// - Frame length is code width plus parity
// - Ignored parity sends 0, odd for 8
// - Realign shifting skips the parity bit
// - Sync DTE transmit clock source selectable
// - Simulation drives ETC, or TC and RC
// - Monitor drives nothing; simulate drives line
// - No zero-bit insertion or removal
`timescale 1ns/1ps
module char_framer (
  input wire logic clk,
  input wire logic rstn,
  input wire framer_pkg::config_t cfg,
  input wire logic [3:0] realignShift,
  input wire logic lineRxData,
  input wire logic lineRxClk,
  input wire logic txValid,
  input wire logic [7:0] txChar,
  output logic txReady,
  output logic lineTxData,
  output logic lineTxDataOe,
  output logic lineClkOut,
  output logic lineClkOutOe,
  output logic lineEtcOe,
  output logic lineRcTcOe,
  output logic capValid,
  output framer_pkg::capture_t capData,
  output logic syncLocked
);

  // ==========================================================
  // Input synchronisers
  logic [1:0] dataSync_q;
  logic [1:0] clkSync_q;
  logic clkPrev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataSync_q <= 2'h3;
      clkSync_q <= 2'h0;
      clkPrev_q <= 1'b0;
    end else begin
      dataSync_q <= {dataSync_q[0], lineRxData};
      clkSync_q <= {clkSync_q[0], lineRxClk};
      clkPrev_q <= clkSync_q[1];
    end
  end

  logic rxBit;
  logic rxRise;
  logic isSync;
  logic [3:0] frameLen;
  logic hasParity;
  assign rxBit = dataSync_q[1];
  assign rxRise = clkSync_q[1] & ~clkPrev_q;
  assign isSync = (cfg.mode == framer_pkg::MODE_SYNC);
  assign hasParity = (cfg.parity != framer_pkg::PAR_NONE);
  assign frameLen = cfg.codeWidth + {3'h0, hasParity};

  // ==========================================================
  // Receive framing: shift on each line clock rise, except in the start and stop states
  typedef enum {RX_HUNT, RX_PAIR, RX_LOCK, RX_START, RX_BITS, RX_STOP} rxState_t;
  rxState_t rxState_q, rxState_d;
  logic [8:0] shift_q, shift_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic frameDone;
  logic [8:0] rawFrame;
  logic [8:0] rxFrame;
  logic [7:0] huntChar;
  logic [7:0] huntXform;
  logic [8:0] huntXfull;
  logic stopErr;
  logic dropSync;
  logic [8:0] shiftIn;

  // Sync char compared after the transform, on the codeWidth character bits of the newest frame
  assign huntChar = cfg.syncOnIdles ? framer_pkg::IDLE_CHAR : cfg.syncChar;

  bit_transform rxXform (
    .din(rawFrame),
    .width(frameLen),
    .msbFirst(cfg.msbFirst),
    .invertSense(cfg.invertSense),
    .dout(rxFrame)
  );

  bit_transform huntXf (
    .din(rawFrame),
    .width(frameLen),
    .msbFirst(cfg.msbFirst),
    .invertSense(cfg.invertSense),
    .dout(huntXfull)
  );
  assign huntXform = huntXfull[7:0] & ((8'h01 << cfg.codeWidth) - 8'h01);

  // Frame bits arrive LSB first into the top of the shift register
  assign shiftIn = {rxBit, shift_q[8:1]};

  // Sync frames end on the rise of their last bit, so look at the bit being shifted in
  always_comb begin
    rawFrame = (isSync ? shiftIn : shift_q) >> (4'h9 - frameLen);
  end

  always_comb begin
    rxState_d = rxState_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    frameDone = 1'b0;
    stopErr = 1'b0;
    if (rxRise) begin
      case (rxState_q)
        RX_HUNT, RX_PAIR, RX_LOCK, RX_BITS: begin
          shift_d = shiftIn;
        end
        default: begin
        end
      endcase
      case (rxState_q)
        RX_HUNT: begin
          if (!isSync) begin
            // This rise may already carry a start bit
            rxState_d = rxBit ? RX_START : RX_BITS;
            bitCnt_d = 4'h0;
          end else if (huntXform == (huntChar & ((8'h01 << cfg.codeWidth) - 8'h01))
              && bitCnt_q >= cfg.codeWidth) begin
            rxState_d = RX_PAIR;
            bitCnt_d = 4'h0;
          end else if (bitCnt_q < 4'hf) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end
        end
        RX_PAIR: begin
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q + 4'h1 == frameLen) begin
            bitCnt_d = 4'h0;
            // Second consecutive sync char at the locked boundary
            if (huntXform == (huntChar & ((8'h01 << cfg.codeWidth) - 8'h01))) begin
              rxState_d = RX_LOCK;
            end else begin
              // History stays valid: hunt resumes at the very next bit position
              rxState_d = RX_HUNT;
              bitCnt_d = frameLen;
            end
          end
        end
        RX_LOCK: begin
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q + 4'h1 == frameLen) begin
            bitCnt_d = 4'h0;
            frameDone = 1'b1;
          end
        end
        RX_START: begin
          if (isSync) begin
            rxState_d = RX_HUNT;
            bitCnt_d = 4'h0;
          end else if (rxBit == 1'b0) begin
            rxState_d = RX_BITS;
            bitCnt_d = 4'h0;
          end
        end
        RX_BITS: begin
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q + 4'h1 == frameLen) begin
            rxState_d = RX_STOP;
          end
        end
        RX_STOP: begin
          // Only one stop bit checked whatever the setting
          stopErr = ~rxBit;
          frameDone = 1'b1;
          rxState_d = RX_START;
        end
        default: begin
          rxState_d = RX_HUNT;
        end
      endcase
    end
    if (dropSync) begin
      rxState_d = RX_HUNT;
      bitCnt_d = 4'h0;
    end
  end

  // ==========================================================
  // Character classification and release
  logic [7:0] rxChar;
  logic rxPar;
  logic inWin_q, inWin_d;
  logic transp_q, transp_d;
  logic relArmed_q, relArmed_d;
  logic [framer_pkg::CNT_W-1:0] relCnt_q, relCnt_d;
  logic [7:0] rxData;
  logic charInWin;
  logic relHit;
  logic store;
  logic parErr;
  framer_pkg::capture_t cap_d;
  logic capValid_d;

  // Realignment shift moves only data bits, parity stays in place
  always_comb begin
    rxData = rxFrame[7:0] & 8'((9'h001 << cfg.codeWidth) - 9'h001);
    rxChar = rxData >> realignShift;
    rxPar = rxFrame[cfg.codeWidth[3:0]];
  end

  always_comb begin
    parErr = 1'b0;
    case (cfg.parity)
      framer_pkg::PAR_EVEN: parErr = ^{rxData, rxPar};
      framer_pkg::PAR_ODD: parErr = ~^{rxData, rxPar};
      default: parErr = 1'b0;
    endcase
  end

  always_comb begin
    inWin_d = inWin_q;
    transp_d = transp_q;
    relArmed_d = relArmed_q;
    relCnt_d = relCnt_q;
    dropSync = 1'b0;
    charInWin = cfg.errCheckOn & inWin_q;
    relHit = 1'b0;
    store = 1'b0;
    capValid_d = 1'b0;
    cap_d = capData;
    if (frameDone) begin
      // Stop char still belongs to the window; start char does not
      charInWin = cfg.errCheckOn & inWin_q;
      if (cfg.errCheckOn && !inWin_q && rxChar == cfg.startOnChar) begin
        inWin_d = 1'b1;
      end else if (inWin_q && rxChar == cfg.stopOnChar) begin
        inWin_d = 1'b0;
      end
      if (!cfg.errCheckOn) begin
        inWin_d = 1'b0;
      end
      if (cfg.transpOn && rxChar == cfg.transpChar) begin
        transp_d = ~transp_q;
      end
      for (int i = 0; i < framer_pkg::RELEASE_N; i++) begin
        if (cfg.releaseOn[i] && rxChar == cfg.releaseChars[i*8 +: 8]
            && (i == 0 ? charInWin : !charInWin)) begin
          relHit = 1'b1;
        end
      end
      // Idles kept only when sync is permanent or in async mode
      store = !(isSync && rxChar == framer_pkg::IDLE_CHAR
        && cfg.releaseOn != '0) && !(isSync && cfg.dropCount != '0
        && rxChar == framer_pkg::IDLE_CHAR);
      if (isSync && relArmed_q) begin
        if (relCnt_q == '0) begin
          dropSync = 1'b1;
          store = 1'b0;
          relArmed_d = 1'b0;
        end else begin
          relCnt_d = relCnt_q - 1'b1;
        end
      end else if (isSync && relHit) begin
        if (cfg.dropCount == '0) begin
          dropSync = 1'b1;
          relArmed_d = 1'b0;
        end else begin
          relArmed_d = 1'b1;
          relCnt_d = cfg.dropCount - 1'b1;
        end
      end
      capValid_d = store;
      cap_d.data = rxChar;
      cap_d.parityBit = hasParity & rxPar;
      cap_d.parityErr = parErr;
      cap_d.framingErr = stopErr;
      cap_d.inWindow = charInWin;
      // Inside the transparent field chars are flagged; window and release chars still act
      cap_d.transparent = cfg.transpOn & transp_q;
    end
    if (dropSync) begin
      inWin_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxState_q <= RX_HUNT;
      shift_q <= 9'h1ff;
      bitCnt_q <= 4'h0;
      inWin_q <= 1'b0;
      transp_q <= 1'b0;
      relArmed_q <= 1'b0;
      relCnt_q <= '0;
      capValid <= 1'b0;
      capData <= '0;
      syncLocked <= 1'b0;
    end else begin
      rxState_q <= rxState_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      inWin_q <= inWin_d;
      transp_q <= transp_d;
      relArmed_q <= relArmed_d;
      relCnt_q <= relCnt_d;
      capValid <= capValid_d;
      capData <= cap_d;
      syncLocked <= (rxState_d == RX_LOCK);
    end
  end

  // ==========================================================
  // Transmit path, simulate only
  logic [8:0] txRaw;
  logic [8:0] txFrame;
  logic [12:0] txShift_q, txShift_d;
  logic [3:0] txLeft_q, txLeft_d;
  logic [3:0] div_q, div_d;
  logic clkOut_q, clkOut_d;
  logic txReady_d, txData_d;
  logic txPar;
  logic [3:0] stopHalf;

  always_comb begin
    txPar = 1'b0;
    case (cfg.parity)
      framer_pkg::PAR_EVEN: txPar = ^txChar;
      framer_pkg::PAR_ODD: txPar = ~^txChar;
      framer_pkg::PAR_IGNORE: txPar = (cfg.codeWidth == framer_pkg::CODE_MAX) ?
        ~^txChar : 1'b0;
      default: txPar = 1'b0;
    endcase
    txRaw = {1'b0, txChar & 8'((9'h001 << cfg.codeWidth) - 9'h001)};
    txRaw[cfg.codeWidth[3:0]] = hasParity & txPar;
  end

  bit_transform txXform (
    .din(txRaw),
    .width(frameLen),
    .msbFirst(cfg.msbFirst),
    .invertSense(cfg.invertSense),
    .dout(txFrame)
  );

  always_comb begin
    case (cfg.mode)
      framer_pkg::MODE_ASYNC15: stopHalf = framer_pkg::STOP_HALF_BITS_15;
      framer_pkg::MODE_ASYNC2: stopHalf = framer_pkg::STOP_HALF_BITS_2;
      default: stopHalf = framer_pkg::STOP_HALF_BITS_1;
    endcase
  end

  // Bit clock from divider; stop bits counted in whole bits (1.5 rounds to 2)
  always_comb begin
    div_d = div_q + 4'h1;
    clkOut_d = clkOut_q;
    txShift_d = txShift_q;
    txLeft_d = txLeft_q;
    txReady_d = 1'b0;
    txData_d = lineTxData;
    if (div_q == cfg.clkDiv) begin
      div_d = 4'h0;
      clkOut_d = ~clkOut_q;
      if (clkOut_q) begin
        if (txLeft_q != 4'h0) begin
          txData_d = txShift_q[0];
          txShift_d = {1'b1, txShift_q[12:1]};
          txLeft_d = txLeft_q - 4'h1;
        end else if (txValid && cfg.simulate) begin
          txReady_d = 1'b1;
          if (isSync) begin
            txData_d = txFrame[0];
            txShift_d = {4'hf, txFrame} >> 1;
            txLeft_d = frameLen - 4'h1;
          end else begin
            txData_d = 1'b0;
            txShift_d = {4'hf, txFrame} | (13'h1fff << frameLen);
            txLeft_d = frameLen + (stopHalf >> 1) + stopHalf[0];
          end
        end else begin
          txData_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txShift_q <= 13'h1fff;
      txLeft_q <= 4'h0;
      div_q <= 4'h0;
      clkOut_q <= 1'b0;
      txReady <= 1'b0;
      lineTxData <= 1'b1;
      lineTxDataOe <= 1'b0;
      lineClkOut <= 1'b0;
      lineClkOutOe <= 1'b0;
      lineEtcOe <= 1'b0;
      lineRcTcOe <= 1'b0;
    end else begin
      txShift_q <= txShift_d;
      txLeft_q <= txLeft_d;
      div_q <= div_d;
      clkOut_q <= clkOut_d;
      txReady <= txReady_d;
      lineTxData <= txData_d;
      lineTxDataOe <= cfg.simulate;
      lineClkOut <= clkOut_d;
      // Clock source choice only matters in synchronous mode
      lineClkOutOe <= cfg.simulate & isSync & (cfg.simDce | cfg.dteClockFromDte);
      lineEtcOe <= cfg.simulate & ~cfg.simDce;
      lineRcTcOe <= cfg.simulate & cfg.simDce;
    end
  end

endmodule // char_framer

// [design/framer_pkg.sv]
// Purpose: shared types and constants for the character sync/async framer
// Assumes: 100 MHz system clock, line clock sampled through two flops
// Notes: all layout and timing figures live here; reset values are set in the framer
package framer_pkg;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    MODE_ASYNC1,
    MODE_ASYNC15,
    MODE_ASYNC2,
    MODE_SYNC
  } lineMode_t;

  typedef enum logic [1:0] {
    PAR_NONE,
    PAR_EVEN,
    PAR_ODD,
    PAR_IGNORE
  } parity_t;

  // ==========================================================
  // Widths and constants
  localparam int CHAR_W = 8;
  localparam int FRAME_W = 9;
  localparam int RELEASE_N = 7;
  localparam int CNT_W = 8;
  localparam logic [7:0] IDLE_CHAR = 8'hff;
  localparam logic [1:0] SYNC_PAIR = 2'h2;
  localparam logic [3:0] CODE_MIN = 4'h5;
  localparam logic [3:0] CODE_MAX = 4'h8;
  localparam logic [3:0] STOP_HALF_BITS_1 = 4'h2;
  localparam logic [3:0] STOP_HALF_BITS_15 = 4'h3;
  localparam logic [3:0] STOP_HALF_BITS_2 = 4'h4;

  // ==========================================================
  // Configuration carrier
  typedef struct packed {
    logic msbFirst;
    logic invertSense;
    lineMode_t mode;
    parity_t parity;
    logic [3:0] codeWidth;
    logic errCheckOn;
    logic [7:0] startOnChar;
    logic [7:0] stopOnChar;
    logic transpOn;
    logic [7:0] transpChar;
    logic syncOnIdles;
    logic [7:0] syncChar;
    logic [CNT_W-1:0] dropCount;
    logic [RELEASE_N-1:0] releaseOn;
    logic [RELEASE_N*8-1:0] releaseChars;
    logic dteClockFromDte;
    logic simulate;
    logic simDce;
    logic [3:0] clkDiv;
  } config_t;

  // Captured character carrier
  typedef struct packed {
    logic [7:0] data;
    logic parityBit;
    logic parityErr;
    logic framingErr;
    logic inWindow;
    logic transparent;
  } capture_t;

endpackage

// [design/bit_transform.sv]
// Purpose: bit order and sense transform of one character frame
// Assumes: data right aligned in the frame, width in bits given
// Notes: pure combinational, used on the receive and transmit paths
`timescale 1ns/1ps
module bit_transform (
  input wire logic [8:0] din,
  input wire logic [3:0] width,
  input wire logic msbFirst,
  input wire logic invertSense,
  output logic [8:0] dout
);

  logic [8:0] rev;

  always_comb begin
    rev = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(width)) begin
        rev[i] = din[int'(width) - 1 - i];
      end
    end
    dout = (msbFirst ? rev : din) ^ (invertSense ? 9'h1ff : 9'h000);
  end

endmodule // bit_transform

// [tb/char_framer_sva.sv]
// Purpose: port checker for char_framer
// Assumes: cfg changes only while the line is idle
// Notes: bound into every char_framer
`timescale 1ns/1ps
module char_framer_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire framer_pkg::config_t cfg,
  input wire logic [3:0] realignShift,
  input wire logic lineRxData,
  input wire logic lineRxClk,
  input wire logic txValid,
  input wire logic [7:0] txChar,
  input wire logic txReady,
  input wire logic lineTxData,
  input wire logic lineTxDataOe,
  input wire logic lineClkOut,
  input wire logic lineClkOutOe,
  input wire logic lineEtcOe,
  input wire logic lineRcTcOe,
  input wire logic capValid,
  input wire framer_pkg::capture_t capData,
  input wire logic syncLocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ====================
  // Enables follow a settled cfg
  sequence settled;
    $past(rstn, 2) && $stable(cfg);
  endsequence
  chk_monitor_quiet: assert property (settled ##0 !cfg.simulate |->
    !lineTxDataOe && !lineClkOutOe && !lineEtcOe && !lineRcTcOe && lineTxData)
    else $error("line driven while monitoring");
  chk_dte_etc: assert property (settled ##0 (cfg.simulate && !cfg.simDce) |->
    lineEtcOe && !lineRcTcOe && lineTxDataOe) else $error("DTE clock enables wrong");
  chk_dce_clocks: assert property (settled ##0 (cfg.simulate && cfg.simDce) |->
    lineRcTcOe && !lineEtcOe) else $error("DCE clock enables wrong");
  chk_clk_source: assert property (settled |-> lineClkOutOe == (cfg.simulate &&
    cfg.mode == framer_pkg::MODE_SYNC && (cfg.simDce || cfg.dteClockFromDte)))
    else $error("clock output enable wrong");
  // ====================
  // Capture and transmit timing
  chk_nocap_unlocked: assert property (capValid && cfg.mode == framer_pkg::MODE_SYNC |->
    syncLocked || $past(syncLocked)) else $error("capture without sync");
  chk_cap_pulse: assert property (capValid |=> !capValid)
    else $error("capture strobe too long");
  chk_ready_pulse: assert property (txReady |-> cfg.simulate ##1 !txReady)
    else $error("bad transmit handshake");
  chk_start_bit: assert property (txReady && cfg.mode != framer_pkg::MODE_SYNC |->
    !lineTxData ##1 !lineTxData) else $error("start bit missing");
  cov_lock: cover property (capValid && syncLocked);
  cov_drop: cover property ($fell(syncLocked));
  cov_send: cover property (txReady);
endmodule // char_framer_sva

bind char_framer char_framer_sva chk (.clk(clk), .rstn(rstn), .cfg(cfg),
  .realignShift(realignShift), .lineRxData(lineRxData), .lineRxClk(lineRxClk),
  .txValid(txValid), .txChar(txChar), .txReady(txReady), .lineTxData(lineTxData),
  .lineTxDataOe(lineTxDataOe), .lineClkOut(lineClkOut), .lineClkOutOe(lineClkOutOe),
  .lineEtcOe(lineEtcOe), .lineRcTcOe(lineRcTcOe), .capValid(capValid),
  .capData(capData), .syncLocked(syncLocked));

// [tb/line_peer.sv]
// Purpose: far-side line equipment driving receive data and clock
// Assumes: 80 ns line clock, only running while bits are sent
// Notes: data changes while the clock is low
`timescale 1ns/1ps
module line_peer (
  output logic lineRxClk,
  output logic lineRxData
);
  initial begin
    lineRxClk = 1'b0;
    lineRxData = 1'b1;
  end
  task automatic sendBit(input logic b);
    lineRxData = b;
    #43 lineRxClk = 1'b1;
    #37 lineRxClk = 1'b0;
  endtask
  // Back to mark once traffic ends
  task automatic idleLine();
    lineRxData = 1'b1;
  endtask
endmodule // line_peer

// [tb/tb_top.sv]
// Purpose: self-checking bench for char_framer
// Assumes: fixed seed, cfg changed only between frames
// Notes: expectations come from the bench functions
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, txValid, txReady, lineRxData, lineRxClk, lineTxData, lineTxDataOe;
  logic lineClkOut, lineClkOutOe, lineEtcOe, lineRcTcOe, capValid, syncLocked, bad;
  logic [7:0] txChar, c;
  logic [8:0] r, seen;
  logic [3:0] realignShift;
  framer_pkg::config_t cfg;
  framer_pkg::capture_t capData;
  framer_pkg::capture_t capQ[$];
  logic [7:0] stream[15] = '{8'h0, 8'h41, 8'h0, 8'h0, 8'h23, 8'hff, 8'h5a, 8'h24, 8'h25,
    8'h26, 8'h3f, 8'h61, 8'h62, 8'he7, 8'he7};
  int error_cnt = 0;
  int n_compared = 0;
  char_framer dut (.clk(clk), .rstn(rstn), .cfg(cfg), .realignShift(realignShift),
    .lineRxData(lineRxData), .lineRxClk(lineRxClk), .txValid(txValid), .txChar(txChar),
    .txReady(txReady), .lineTxData(lineTxData), .lineTxDataOe(lineTxDataOe),
    .lineClkOut(lineClkOut), .lineClkOutOe(lineClkOutOe), .lineEtcOe(lineEtcOe),
    .lineRcTcOe(lineRcTcOe), .capValid(capValid), .capData(capData),
    .syncLocked(syncLocked));
  line_peer peer (.lineRxClk(lineRxClk), .lineRxData(lineRxData));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (capValid) capQ.push_back(capData);
  // ====================
  // Helpers
  task automatic check(input string what, input logic [11:0] seenV, input logic [11:0] exp);
    n_compared++;
    if (seenV !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seenV);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic int flen();
    return int'(cfg.codeWidth) + (cfg.parity != framer_pkg::PAR_NONE ? 1 : 0);
  endfunction
  function automatic logic [8:0] mask(input int n);
    return 9'h1ff >> (9 - n);
  endfunction
  // Frame bits in line order
  function automatic logic [8:0] wireFrame(input logic [7:0] ch);
    logic [8:0] f;
    logic [8:0] o;
    int w;
    w = int'(cfg.codeWidth);
    f = 9'(ch) & mask(w);
    case (cfg.parity)
      framer_pkg::PAR_EVEN: f[w] = ^f;
      framer_pkg::PAR_ODD: f[w] = ~^f;
      framer_pkg::PAR_IGNORE: f[w] = (w == 8) ? ~^f : 1'b0;
      default: ;
    endcase
    o = f;
    if (cfg.msbFirst) for (int i = 0; i < flen(); i++) o[i] = f[flen() - 1 - i];
    if (cfg.invertSense) o = ~o;
    return o;
  endfunction
  function automatic int cnt(input logic [7:0] v);
    int n = 0;
    foreach (capQ[i]) if (capQ[i].data === v) n++;
    return n;
  endfunction
  function automatic framer_pkg::capture_t capOf(input logic [7:0] v);
    foreach (capQ[i]) if (capQ[i].data === v) return capQ[i];
    return 'x;
  endfunction
  task automatic sendFrame(input logic [7:0] ch, input logic async);
    logic [8:0] o;
    o = wireFrame(ch);
    if (bad) o[cfg.msbFirst ? 0 : flen() - 1] ^= 1'b1;
    if (async) peer.sendBit(1'b0);
    for (int i = 0; i < flen(); i++) peer.sendBit(o[i]);
    if (async) peer.sendBit(1'b1);
  endtask
  task automatic runSync(input logic idles);
    cfg = '0;
    cfg.mode = framer_pkg::MODE_SYNC;
    cfg.codeWidth = 4'h8;
    // All-ones hunt is one bit ambiguous after a char ending in ones
    cfg.msbFirst = idles ? 1'b0 : 1'($urandom);
    cfg.invertSense = 1'($urandom);
    cfg.syncOnIdles = idles;
    cfg.syncChar = 8'h16;
    cfg.dropCount = idles ? 8'h0 : 8'h2;
    cfg.releaseOn = idles ? 7'h0 : 7'h03;
    cfg.releaseChars = 56'h3f5a;
    cfg.errCheckOn = !idles;
    cfg.startOnChar = 8'h24;
    cfg.stopOnChar = 8'h25;
    cfg.transpOn = !idles;
    cfg.transpChar = 8'h24;
    realignShift = 4'h0;
    bad = 1'b0;
    tick();
    capQ.delete();
    repeat (3) peer.sendBit(1'($urandom));
    for (int k = 0; k < 15; k++) begin
      sendFrame((k == 0 || k == 2 || k == 3) ? (idles ? 8'hff : 8'h16) : stream[k], 1'b0);
      if (k == 2) check("early lock", 12'({syncLocked, capQ.size() != 0}), 12'h0);
    end
    peer.idleLine();
    repeat (20) tick();
    check("data kept", {4'(cnt(8'h23)), 4'(cnt(8'h24)), 4'(cnt(8'h26))}, 12'h111);
    seen = 9'({capOf(8'h24).inWindow, capOf(8'h25).inWindow, capOf(8'h26).inWindow,
      capOf(8'h23).transparent, capOf(8'h25).transparent});
    check("window flags", 12'(seen), idles ? 12'h0 : 12'h9);
    check("release char", 12'(cnt(8'h3f)), 12'h1);
    check("idle stored", 12'(cnt(8'hff) != 0), 12'(idles));
    check("after drop", 12'(cnt(8'he7)), idles ? 12'h2 : 12'h0);
    check("lock held", 12'(syncLocked), 12'(idles));
  endtask
  // ====================
  // Watchdog
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    final_report();
  end
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h3ee9));
    rstn = 1'b0;
    cfg = '0;
    cfg.codeWidth = 4'h8;
    realignShift = 4'h0;
    txValid = 1'b0;
    txChar = 8'h0;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) tick();
    check("reset outputs", 12'({txReady, capValid, syncLocked, lineTxData}), 12'h1);
    for (int k = 0; k < 24; k++) begin
      c = 8'($urandom);
      cfg.mode = framer_pkg::lineMode_t'(2'($urandom % 3));
      cfg.parity = framer_pkg::parity_t'(2'($urandom % 3));
      cfg.codeWidth = 4'(5 + k % 4);
      cfg.msbFirst = (k < 2) ? 1'b0 : 1'($urandom);
      realignShift = (k < 4) ? 4'h0 : 4'($urandom % 4);
      bad = cfg.parity != framer_pkg::PAR_NONE && $urandom % 4 == 0;
      tick();
      capQ.delete();
      sendFrame(c, 1'b1);
      for (int i = 0; i < 60 && capQ.size() == 0; i++) tick();
      check("rx count", 12'(capQ.size()), 12'h1);
      check("rx data", 12'(capQ[0].data), 12'((9'(c) & mask(int'(cfg.codeWidth))) >>
        realignShift));
      check("rx errors", 12'({capQ[0].parityErr, capQ[0].framingErr}), 12'({bad, 1'b0}));
    end
    runSync(1'b0);
    runSync(1'b1);
    cfg = '0;
    cfg.codeWidth = 4'h8;
    txValid = 1'b1;
    repeat (100) begin
      tick();
      check("monitor send", 12'(txReady), 12'h0);
    end
    txValid = 1'b0;
    cfg.simulate = 1'b1;
    cfg.parity = framer_pkg::PAR_IGNORE;
    cfg.clkDiv = 4'h3;
    for (int k = 0; k < 8; k++) begin
      cfg.mode = framer_pkg::lineMode_t'(2'($urandom % 3));
      cfg.codeWidth = 4'(5 + k % 4);
      cfg.msbFirst = 1'($urandom);
      cfg.simDce = 1'($urandom);
      cfg.dteClockFromDte = 1'($urandom);
      c = 8'($urandom);
      txChar = c;
      tick();
      txValid = 1'b1;
      for (int i = 0; i < 300 && txReady !== 1'b1; i++) tick();
      txValid = 1'b0;
      r = wireFrame(c);
      seen = '0;
      repeat (4) tick();
      bad = lineTxData;
      for (int i = 0; i < flen(); i++) begin
        repeat (8) tick();
        seen[i] = lineTxData;
      end
      repeat (8) tick();
      check("tx frame", 12'({lineTxData, seen, bad}), 12'({1'b1, r & mask(flen()), 1'b0}));
      check("clock enables", 12'({lineEtcOe, lineRcTcOe}), 12'({~cfg.simDce, cfg.simDce}));
    end
    final_report();
  end
endmodule // tb_top
